// ==== hdl/adrr_analog_regs.sv ====
// Operation
// [RL1] revision register: full mask 3-2, metal 1-0
// [RL2] new mask release carries incremented revision value
// [RL3] offsets decoded from 0x0200 blocking, 0x300 non-blocking
// [RL4] option 1 has current sense; option 2 lacks it
// [RL5] reduced option: host leaves current sense control zero
// [RL6] reduced option: host writes channel nine enable zero
// [RL7] reduced option: host ignores channel nine flag, result
// [RL8] reduced option: no current sense, no channel nine
// [RL9] writes to revision register have no effect
`timescale 1ns/1ps
module adrr_analog_regs
   import adrr_pkg::*;
#(
   parameter logic [1:0] DIE_OPTION     = OPTION_FULL,
   // revision values are arbitrary; each mask release bumps them
   parameter logic [1:0] FULL_MASK_REV  = 2'h0,
   parameter logic [1:0] METAL_MASK_REV = 2'h0
)
(
   input  wire logic                ref_clk,     // clock, 20 MHz
   input  wire logic                rst_n,       // async reset, low
   adrr_d2d_if.dev                  bus,         // die-to-die bus
   input  wire logic [15:0]         convDone,    // channel done pulses
   input  wire logic [ADC_BITS-1:0] resultNine,  // channel 9 sample
   output logic [7:0]               csControl,   // current sense ctrl
   output logic [15:0]              chanEnable   // conversion enables
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                ack;
      logic                err;
      logic [7:0]          rdata;
      logic [7:0]          csCtrl;
      logic [15:0]         chanEn;
      logic [15:0]         done;
      logic [ADC_BITS-1:0] resNine;
   } adrr_dev_s;

   localparam logic        HAS_SENSE = (DIE_OPTION == OPTION_FULL);
   // the unbonded channel never reports; channel 9 never reports on the reduced option
   localparam logic [15:0] DEAD_CH   = HAS_SENSE ? CH_ABSENT_MASK
                                     : (CH_ABSENT_MASK | CH_NINE_MASK);

   // one done flag per conversion channel
   localparam int N_CHAN = $bits(CH_EN_RESET);

   adrr_dev_s st_r;
   adrr_dev_s st_nxt;

   logic        hitBlk;
   logic        hitNbk;
   logic [7:0]  ofs;
   logic        enWrite;
   logic [15:0] clearMask;
   logic [15:0] setMask;
   logic [15:0] doneNxt;
   logic [7:0]  revByte;

   // flags that a write of d to enable byte o restarts and clears
   function automatic logic [15:0] enableClear(input logic [7:0] o,
                                               input logic [7:0] d);
      enableClear = 16'h0000;
      if (o == OFS_CH_EN_HI)
      begin
         enableClear[15:8] = d;
      end
      else if (o == OFS_CH_EN_LO)
      begin
         enableClear[7:0] = d;
      end
   endfunction

   assign revByte = {4'h0, FULL_MASK_REV, METAL_MASK_REV};  // RL1 RL2

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   assign hitBlk  = inWindow(bus.addr, BLOCKING_BASE);       // RL3
   assign hitNbk  = inWindow(bus.addr, NONBLOCK_BASE);       // RL3
   assign ofs     = bus.addr[7:0];
   assign enWrite = bus.req && bus.write && (hitBlk || hitNbk);

   // ----------------------------------------------------------------
   // conversion done flags
   // ----------------------------------------------------------------
   // kept out of the next-state process so that the flag logic never
   // feeds back into the decode that produces its clear strobe
   assign clearMask = enWrite ? enableClear(ofs, bus.wdata) : 16'h0000;
   assign setMask   = convDone & ~DEAD_CH;                    // RL8

   generate
      for (genvar ch = 0; ch < N_CHAN; ch++)
      begin : g_done
         // a done pulse in the same cycle as the clear wins
         assign doneNxt[ch] = setMask[ch]
                              || (st_r.done[ch] && !clearMask[ch]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt     = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.err = 1'b0;

      // latest channel 9 sample, only when that channel exists
      if (HAS_SENSE && |(convDone & CH_NINE_MASK))    // RL4
      begin
         st_nxt.resNine = resultNine;
      end

      if (bus.req)
      begin
         st_nxt.ack   = 1'b1;
         st_nxt.rdata = 8'h00;
         if (!(hitBlk || hitNbk))
         begin
            st_nxt.err = 1'b1;
         end
         else if (bus.write)
         begin
            unique case (ofs)
               OFS_CS_CTRL:
               begin
                  // absent module: register stays at reset value
                  if (HAS_SENSE)                      // RL8
                  begin
                     st_nxt.csCtrl = bus.wdata;
                  end
               end
               OFS_CH_EN_HI:
               begin
                  st_nxt.chanEn[15:8] = bus.wdata & ~DEAD_CH[15:8];
               end
               OFS_CH_EN_LO:
               begin
                  st_nxt.chanEn[7:0] = bus.wdata & ~DEAD_CH[7:0];
               end
               // read-only registers swallow writes silently
               OFS_SIL_REV, OFS_DONE_HI, OFS_DONE_LO,
               OFS_RES9_HI, OFS_RES9_LO:
               begin
                  st_nxt.err = 1'b0;                  // RL9
               end
               default:
               begin
                  st_nxt.err = 1'b1;
               end
            endcase
         end
         else
         begin
            unique case (ofs)
               OFS_CS_CTRL:  st_nxt.rdata = st_r.csCtrl;
               OFS_CH_EN_HI: st_nxt.rdata = st_r.chanEn[15:8];
               OFS_CH_EN_LO: st_nxt.rdata = st_r.chanEn[7:0];
               OFS_DONE_HI:  st_nxt.rdata = st_r.done[15:8];
               OFS_DONE_LO:  st_nxt.rdata = st_r.done[7:0];
               OFS_RES9_HI:
               begin
                  st_nxt.rdata = st_r.resNine[ADC_BITS-1:2];
               end
               OFS_RES9_LO:
               begin
                  st_nxt.rdata = {st_r.resNine[1:0], 6'h00};
               end
               OFS_SIL_REV:  st_nxt.rdata = revByte;  // RL1
               default:
               begin
                  st_nxt.err = 1'b1;
               end
            endcase
         end
      end

      st_nxt.done = doneNxt;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r.ack     <= 1'b0;
         st_r.err     <= 1'b0;
         st_r.rdata   <= 8'h00;
         st_r.csCtrl  <= CS_CTRL_RESET;
         st_r.chanEn  <= CH_EN_RESET;
         st_r.done    <= DONE_RESET;
         st_r.resNine <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign bus.ack    = st_r.ack;
   assign bus.err    = st_r.err;
   assign bus.rdata  = st_r.rdata;
   assign csControl  = st_r.csCtrl;
   assign chanEnable = st_r.chanEn;

endmodule // adrr_analog_regs

// ==== hdl/adrr_d2d_if.sv ====
`timescale 1ns/1ps
interface adrr_d2d_if
(
   input wire logic ref_clk,   // shared clock
   input wire logic rst_n      // asynchronous reset, active low
);
   logic        req;           // one-cycle access request
   logic        write;         // 1 write, 0 read
   logic [15:0] addr;          // global address
   logic [7:0]  wdata;         // write data
   logic        ack;           // one-cycle answer
   logic        err;           // answer flags an address outside both windows or an unmapped offset
   logic [7:0]  rdata;         // read data, valid with ack

   modport dev  (input  req, write, addr, wdata,
                 output ack, err, rdata);
   modport host (output req, write, addr, wdata,
                 input  ack, err, rdata);
endinterface

// ==== hdl/adrr_mcu_port.sv ====
`timescale 1ns/1ps
module adrr_mcu_port
   import adrr_pkg::*;
#(
   parameter logic [1:0] DIE_OPTION = OPTION_FULL
)
(
   input  wire logic       ref_clk,       // clock, 20 MHz
   input  wire logic       rst_n,         // async reset, low
   adrr_d2d_if.host        bus,           // die-to-die bus
   input  wire logic       userReq,       // one-cycle access request
   input  wire logic       userWrite,     // 1 write, 0 read
   input  wire logic       userBlocking,  // 1 blocking window
   input  wire logic [7:0] userOffset,    // register offset
   input  wire logic [7:0] userWdata,     // write data
   output logic            userBusy,      // access in flight
   output logic            userDone,      // one-cycle completion
   output logic [7:0]      userRdata,     // read data, with done
   output logic            userError,     // unmapped read or blocking write, with done
   output logic            userRefused    // one-cycle refusal
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      H_IDLE = 2'b01,
      H_WAIT = 2'b10
   } adrr_host_e;

   typedef struct packed {
      adrr_host_e  fsm;
      logic        posted;
      logic        req;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        busy;
      logic        done;
      logic [7:0]  rdata;
      logic        error;
      logic        refused;
   } adrr_host_s;

   localparam logic REDUCED = (DIE_OPTION == OPTION_REDUCED);  // RL4

   adrr_host_s st_r;
   adrr_host_s st_nxt;
   logic [7:0] ofsSent;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt         = st_r;
      st_nxt.req     = 1'b0;
      st_nxt.done    = 1'b0;
      st_nxt.error   = 1'b0;
      st_nxt.refused = 1'b0;
      ofsSent        = st_r.addr[7:0];
      unique case (st_r.fsm)
         H_IDLE:
         begin
            if (userReq)
            begin
               if (REDUCED && userWrite && userOffset == OFS_CS_CTRL
                   && userWdata != CS_CTRL_RESET)
               begin
                  st_nxt.refused = 1'b1;                       // RL5
               end
               else
               begin
                  st_nxt.req   = 1'b1;
                  st_nxt.write = userWrite;
                  st_nxt.addr  = (userBlocking ? BLOCKING_BASE
                                  : NONBLOCK_BASE)
                                 | {8'h00, userOffset};        // RL3
                  st_nxt.wdata = userWdata;
                  if (REDUCED && userOffset == OFS_CH_EN_HI)
                  begin
                     st_nxt.wdata = userWdata & ~HI_NINE_MASK; // RL6
                  end
                  // posted write: done pulses at once, busy holds until the bus answer
                  st_nxt.posted = userWrite && !userBlocking;
                  st_nxt.done   = userWrite && !userBlocking;
                  st_nxt.busy   = 1'b1;
                  st_nxt.fsm    = H_WAIT;
               end
            end
         end
         H_WAIT:
         begin
            if (bus.ack)
            begin
               st_nxt.busy  = 1'b0;
               st_nxt.fsm   = H_IDLE;
               st_nxt.done  = !st_r.posted;
               st_nxt.error = bus.err && !st_r.posted;
               st_nxt.rdata = bus.rdata;
               if (REDUCED && !st_r.write)
               begin
                  if (ofsSent == OFS_DONE_HI)
                  begin
                     st_nxt.rdata = bus.rdata & ~HI_NINE_MASK; // RL7
                  end
                  else if (ofsSent == OFS_RES9_HI
                           || ofsSent == OFS_RES9_LO)
                  begin
                     st_nxt.rdata = 8'h00;                     // RL7
                  end
               end
            end
         end
         default:
         begin
            st_nxt.fsm  = H_IDLE;
            st_nxt.busy = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r.fsm     <= H_IDLE;
         st_r.posted  <= 1'b0;
         st_r.req     <= 1'b0;
         st_r.write   <= 1'b0;
         st_r.addr    <= 16'h0000;
         st_r.wdata   <= 8'h00;
         st_r.busy    <= 1'b0;
         st_r.done    <= 1'b0;
         st_r.rdata   <= 8'h00;
         st_r.error   <= 1'b0;
         st_r.refused <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign bus.req     = st_r.req;
   assign bus.write   = st_r.write;
   assign bus.addr    = st_r.addr;
   assign bus.wdata   = st_r.wdata;
   assign userBusy    = st_r.busy;
   assign userDone    = st_r.done;
   assign userRdata   = st_r.rdata;
   assign userError   = st_r.error;
   assign userRefused = st_r.refused;

endmodule // adrr_mcu_port

// ==== hdl/adrr_pkg.sv ====
package adrr_pkg;

   // ----------------------------------------------------------------
   // global address windows
   // ----------------------------------------------------------------
   localparam logic [15:0] BLOCKING_BASE  = 16'h0200;
   localparam logic [15:0] NONBLOCK_BASE  = 16'h0300;
   localparam logic [15:0] WINDOW_MASK    = 16'hff00;

   // ----------------------------------------------------------------
   // register offsets inside a window
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CS_CTRL     = 8'h3c;
   localparam logic [7:0] OFS_CH_EN_HI    = 8'h82;
   localparam logic [7:0] OFS_CH_EN_LO    = 8'h83;
   localparam logic [7:0] OFS_DONE_HI     = 8'h84;
   localparam logic [7:0] OFS_DONE_LO     = 8'h85;
   localparam logic [7:0] OFS_RES9_HI     = 8'h98;
   localparam logic [7:0] OFS_RES9_LO     = 8'h99;
   localparam logic [7:0] OFS_SIL_REV     = 8'hf4;

   // ----------------------------------------------------------------
   // fields, reset values, options
   // ----------------------------------------------------------------
   localparam logic [7:0]  CS_CTRL_RESET  = 8'h00;
   localparam logic [15:0] CH_EN_RESET    = 16'h0000;
   localparam logic [15:0] DONE_RESET     = 16'h0000;
   localparam logic [15:0] CH_NINE_MASK   = 16'h0200;
   localparam logic [15:0] CH_ABSENT_MASK = 16'h2000;
   localparam logic [7:0]  HI_NINE_MASK   = 8'h02;
   localparam int          ADC_BITS       = 10;
   localparam int          REV_FIELD_BITS = 2;
   localparam logic [1:0]  OPTION_FULL    = 2'h1;
   localparam logic [1:0]  OPTION_REDUCED = 2'h2;

   // true when the global address falls into the given window
   function automatic logic inWindow(input logic [15:0] addr,
                                     input logic [15:0] base);
      inWindow = (addr & WINDOW_MASK) == base;
   endfunction

endpackage

// ==== verif/adrr_assertions.sv ====
`timescale 1ns/1ps
module adrr_assertions
   import adrr_pkg::*;
#(
   parameter logic [1:0] FULL_MASK_REV  = 2'h0,
   parameter logic [1:0] METAL_MASK_REV = 2'h0
)
(
   input wire logic        ref_clk,  // clock
   input wire logic        rst_n,    // async reset, low
   input wire logic        req,      // access request
   input wire logic        write,    // write select
   input wire logic [15:0] addr,     // global address
   input wire logic [7:0]  wdata,    // write data
   input wire logic        ack,      // answer
   input wire logic        err,      // error flag
   input wire logic [7:0]  rdata     // read data
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   logic mapped;
   logic revAddr;
   logic csAddr;
   logic knownOfs;
   logic [7:0] csShadow;
   assign mapped  = inWindow(addr, BLOCKING_BASE)
                    || inWindow(addr, NONBLOCK_BASE);
   assign revAddr = mapped && (addr[7:0] == OFS_SIL_REV);
   assign csAddr  = mapped && (addr[7:0] == OFS_CS_CTRL);
   assign knownOfs = addr[7:0] inside {OFS_CS_CTRL, OFS_CH_EN_HI,
                        OFS_CH_EN_LO, OFS_DONE_HI, OFS_DONE_LO,
                        OFS_RES9_HI, OFS_RES9_LO, OFS_SIL_REV};

   // last value written to the current sense control register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         csShadow <= CS_CTRL_RESET;
      else if (req && write && csAddr)
         csShadow <= wdata;
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   sequence s_csWrite;
      req && write && csAddr;
   endsequence
   sequence s_csRead;
      req && !write && csAddr;
   endsequence

   property p_ackAfterReq;
      req |=> ack;
   endproperty
   property p_ackCause;
      ack |-> $past(req);
   endproperty
   property p_revRead;
      req && !write && revAddr |=> ack && !err
         && rdata == {4'h0, FULL_MASK_REV, METAL_MASK_REV};
   endproperty
   property p_revWrite;
      req && write && revAddr |=> ack && !err;
   endproperty
   property p_outside;
      req && !(mapped && knownOfs) |=> ack && err;
   endproperty
   property p_csWrite;
      s_csWrite |=> ack && !err;
   endproperty
   property p_errWithAck;
      err |-> ack;
   endproperty
   property p_errData;
      ack && err |-> rdata == 8'h00;
   endproperty
   // a shadow keeps the last write, so reads may come any time later
   property p_csReadback;
      s_csRead |=> ack && rdata == csShadow;
   endproperty

   a_ackAfterReq: assert property (p_ackAfterReq)
      else $error("request not answered next cycle");
   a_ackCause: assert property (p_ackCause)
      else $error("answer without request");
   a_revRead: assert property (p_revRead)
      else $error("revision read value wrong");
   a_revWrite: assert property (p_revWrite)
      else $error("revision write answered wrongly");
   a_outside: assert property (p_outside)
      else $error("unmapped access not flagged");
   a_csWrite: assert property (p_csWrite)
      else $error("current sense control write answered wrongly");
   a_errWithAck: assert property (p_errWithAck)
      else $error("error flag without answer");
   a_errData: assert property (p_errData)
      else $error("error answer carries data");
   a_csReadback: assert property (p_csReadback)
      else $error("current sense control readback wrong");
endmodule // adrr_assertions

// ==== verif/test_analog_die_revision_option_regs.sv ====
`timescale 1ns/1ps
module test_analog_die_revision_option_regs;
   import adrr_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic userReq = 1'b0, userWrite = 1'b0, userBlocking = 1'b0;
   logic [7:0] userOffset = 8'h00, userWdata = 8'h00;
   logic userBusy, userDone, userError, userRefused;
   logic [7:0] userRdata, csA, csB, rd;
   logic [15:0] chA, chB;
   // reduced host on a third link, fed the same user requests
   logic cBusy, cDone, cError, cRefused;
   logic [7:0] cRdata, csC, rdC;
   logic [15:0] chC;
   logic [15:0] convDone = 16'h0000;
   logic [ADC_BITS-1:0] resultNine = 10'h2a5;
   logic er, erC, dnC, refA, refC;
   // arbitrary nonzero revision so that both fields are seen
   localparam logic [1:0] FM_REV = 2'h2;
   localparam logic [1:0] MM_REV = 2'h1;
   localparam logic [7:0] REV_BYTE = {4'h0, FM_REV, MM_REV};
   int nErrors = 0, nTests = 0;

   always #25 ref_clk = ~ref_clk;

   adrr_d2d_if u_adrr_d2d_if (.ref_clk(ref_clk), .rst_n(rst_n));
   // second link: the bench plays a host that breaks the reduced rules
   adrr_d2d_if u_adrr_d2d_if_b (.ref_clk(ref_clk), .rst_n(rst_n));
   adrr_analog_regs #(.DIE_OPTION(OPTION_FULL), .FULL_MASK_REV(FM_REV),
      .METAL_MASK_REV(MM_REV)) u_adrr_analog_regs (
      .ref_clk(ref_clk), .rst_n(rst_n), .bus(u_adrr_d2d_if),
      .convDone(convDone), .resultNine(resultNine),
      .csControl(csA), .chanEnable(chA));
   adrr_mcu_port #(.DIE_OPTION(OPTION_FULL)) u_adrr_mcu_port (
      .ref_clk(ref_clk), .rst_n(rst_n), .bus(u_adrr_d2d_if),
      .userReq(userReq), .userWrite(userWrite),
      .userBlocking(userBlocking), .userOffset(userOffset),
      .userWdata(userWdata), .userBusy(userBusy), .userDone(userDone),
      .userRdata(userRdata), .userError(userError),
      .userRefused(userRefused));
   adrr_analog_regs #(.DIE_OPTION(OPTION_REDUCED), .FULL_MASK_REV(FM_REV),
      .METAL_MASK_REV(MM_REV)) u_adrr_analog_regs_b (
      .ref_clk(ref_clk), .rst_n(rst_n), .bus(u_adrr_d2d_if_b),
      .convDone(convDone), .resultNine(resultNine),
      .csControl(csB), .chanEnable(chB));
   adrr_assertions #(.FULL_MASK_REV(FM_REV), .METAL_MASK_REV(MM_REV))
      u_adrr_assertions (
      .ref_clk(ref_clk), .rst_n(rst_n), .req(u_adrr_d2d_if.req),
      .write(u_adrr_d2d_if.write), .addr(u_adrr_d2d_if.addr),
      .wdata(u_adrr_d2d_if.wdata), .ack(u_adrr_d2d_if.ack),
      .err(u_adrr_d2d_if.err), .rdata(u_adrr_d2d_if.rdata));
   adrr_d2d_if u_adrr_d2d_if_c (.ref_clk(ref_clk), .rst_n(rst_n));
   adrr_mcu_port #(.DIE_OPTION(OPTION_REDUCED)) u_adrr_mcu_port_c (
      .ref_clk(ref_clk), .rst_n(rst_n), .bus(u_adrr_d2d_if_c),
      .userReq(userReq), .userWrite(userWrite),
      .userBlocking(userBlocking), .userOffset(userOffset),
      .userWdata(userWdata), .userBusy(cBusy), .userDone(cDone),
      .userRdata(cRdata), .userError(cError),
      .userRefused(cRefused));
   adrr_analog_regs #(.DIE_OPTION(OPTION_REDUCED), .FULL_MASK_REV(FM_REV),
      .METAL_MASK_REV(MM_REV)) u_adrr_analog_regs_c (
      .ref_clk(ref_clk), .rst_n(rst_n), .bus(u_adrr_d2d_if_c),
      .convDone(convDone), .resultNine(resultNine),
      .csControl(csC), .chanEnable(chC));
   initial
   begin
      u_adrr_d2d_if_b.req = 1'b0;
      u_adrr_d2d_if_b.write = 1'b0;
      u_adrr_d2d_if_b.addr = 16'h0000;
      u_adrr_d2d_if_b.wdata = 8'h00;
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic stopTest();
      if (nErrors == 0 && nTests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
      nTests++;
      if (got !== exp)
      begin
         nErrors++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chkFlag(input logic got, input logic exp);
      nTests++;
      if (got !== exp)
      begin
         nErrors++;
         $display("MISMATCH %0t flag %b want %b", $time, got, exp);
      end
   endtask
   task automatic hang();
      nErrors++;
      $display("MISMATCH %0t no completion", $time);
      stopTest();
   endtask
   // user side access; waits for the one-cycle done pulse
   task automatic uAcc(input logic blk, input logic wr,
                       input logic [7:0] ofs, input logic [7:0] wd);
      int i;
      userReq <= 1'b1;
      userBlocking <= blk;
      userWrite <= wr;
      userOffset <= ofs;
      userWdata <= wd;
      @(negedge ref_clk);
      userReq <= 1'b0;
      refA = userRefused;
      refC = cRefused;
      for (i = 0; i < 8 && userDone !== 1'b1; i++)
         @(negedge ref_clk);
      if (userDone !== 1'b1)
         hang();
      rd = userRdata;
      er = userError;
      rdC = cRdata;
      erC = cError;
      dnC = cDone;
      // a posted write is done before its bus answer: wait for idle
      for (i = 0; i < 8 && (userBusy || cBusy) !== 1'b0; i++)
         @(negedge ref_clk);
      if ((userBusy || cBusy) !== 1'b0)
         hang();
      @(negedge ref_clk);
   endtask
   // direct bus access on the second link
   task automatic bAcc(input logic wr, input logic [15:0] a,
                       input logic [7:0] wd);
      int i;
      u_adrr_d2d_if_b.req <= 1'b1;
      u_adrr_d2d_if_b.write <= wr;
      u_adrr_d2d_if_b.addr <= a;
      u_adrr_d2d_if_b.wdata <= wd;
      @(negedge ref_clk);
      u_adrr_d2d_if_b.req <= 1'b0;
      for (i = 0; i < 4 && u_adrr_d2d_if_b.ack !== 1'b1; i++)
         @(negedge ref_clk);
      if (u_adrr_d2d_if_b.ack !== 1'b1)
         hang();
      rd = u_adrr_d2d_if_b.rdata;
      er = u_adrr_d2d_if_b.err;
      @(negedge ref_clk);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(negedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      chkByte(csA, CS_CTRL_RESET);
      chkByte(csC, CS_CTRL_RESET);
      chkByte(chA[15:8], CH_EN_RESET[15:8]);
      uAcc(1'b1, 1'b0, OFS_SIL_REV, 8'h00);
      chkByte(rd, REV_BYTE);
      chkByte(rdC, REV_BYTE);
      uAcc(1'b1, 1'b1, OFS_SIL_REV, 8'hff);
      uAcc(1'b0, 1'b0, OFS_SIL_REV, 8'h00);
      chkByte(rd, REV_BYTE);
      uAcc(1'b1, 1'b1, OFS_CS_CTRL, 8'ha5);
      chkFlag(refA, 1'b0);
      chkFlag(refC, 1'b1);
      chkFlag(dnC, 1'b0);
      uAcc(1'b0, 1'b0, OFS_CS_CTRL, 8'h00);
      chkByte(rd, 8'ha5);
      chkByte(rdC, CS_CTRL_RESET);
      chkByte(csA, 8'ha5);
      chkByte(csC, CS_CTRL_RESET);
      uAcc(1'b1, 1'b1, OFS_CH_EN_HI, 8'hff);
      uAcc(1'b1, 1'b0, OFS_CH_EN_HI, 8'h00);
      chkByte(rd, 8'hdf);
      chkByte(rdC, 8'hdd);
      chkFlag(chC[9], 1'b0);
      uAcc(1'b0, 1'b1, OFS_CH_EN_LO, 8'h5a);
      chkFlag(dnC, 1'b1);
      uAcc(1'b1, 1'b0, OFS_CH_EN_LO, 8'h00);
      chkByte(rd, 8'h5a);
      chkByte(chC[7:0], 8'h5a);
      uAcc(1'b1, 1'b0, 8'h00, 8'h00);
      chkFlag(er, 1'b1);
      chkFlag(erC, 1'b1);
      convDone <= CH_NINE_MASK;
      @(negedge ref_clk);
      convDone <= 16'h0000;
      uAcc(1'b1, 1'b0, OFS_DONE_HI, 8'h00);
      chkByte(rd, HI_NINE_MASK);
      chkByte(rdC, 8'h00);
      uAcc(1'b1, 1'b0, OFS_RES9_HI, 8'h00);
      chkByte(rd, 8'ha9);
      chkByte(rdC, 8'h00);
      uAcc(1'b1, 1'b0, OFS_RES9_LO, 8'h00);
      chkByte(rd, 8'h40);
      chkByte(rdC, 8'h00);
      // reduced die, host breaking its rules on purpose
      bAcc(1'b1, 16'h023c, 8'hff);
      bAcc(1'b0, 16'h023c, 8'h00);
      chkByte(rd, 8'h00);
      chkByte(csB, 8'h00);
      // flags read before any enable write could have cleared them
      bAcc(1'b0, 16'h0284, 8'h00);
      chkFlag(rd[1], 1'b0);
      bAcc(1'b1, 16'h0382, 8'hff);
      chkFlag(chB[9], 1'b0);
      chkByte(chB[15:8], 8'hdd);
      bAcc(1'b0, 16'h0400, 8'h00);
      chkFlag(er, 1'b1);
      stopTest();
   end
endmodule // test_analog_die_revision_option_regs
